/* File: rtl/frb_defines.svh */
// Function
// - wait meaningful only in synchronous array reads
// - page reads and 4/8/16/continuous bursts
// - array mode returns stored addressed data
// - identifier mode returns codes, no array data
// - query mode returns interface table only
// - status mode returns partition status register
// - bursts advance address on each active clock edge: rising, or falling when clk_fall is set
// - non-array reads are single words, no sequencing
// - wait asserted during non-array single reads
// - modes set by command only, not supply
// - reset gives array mode, asynchronous reads
// - reads enabled only with chip select
// - upper address bits select the partition
// - address valid makes address latches transparent
// - output enable drives selected data out
// - asynchronous capture whenever the address changes while address valid is asserted
// - synchronous capture on first valid edge
// - deselect floats outputs, ignores output enable
// - reset floats outputs, aborts internal work
// - halted clock suspends burst, resumes later
`ifndef FRB_DEFINES_SVH
`define FRB_DEFINES_SVH
`define FRB_WORD_W       16
`define FRB_PART_OFF_W   18
`define FRB_ADDR_MAX_W   32
`define FRB_PART_MAX_W   8
`define FRB_FIFO_DEPTH   32
`define FRB_PIN_CLK      4
`define FRB_PIN_CE       3
`define FRB_PIN_OE       2
`define FRB_PIN_WE       1
`define FRB_PIN_ADV      0
`define FRB_PIN_W        5
`define FRB_CLK_PERIOD_PS 4000
`define FRB_RST_PW_NS    100
`define FRB_RST_PW_CYC   ((`FRB_RST_PW_NS * 1000 + `FRB_CLK_PERIOD_PS - 1) / `FRB_CLK_PERIOD_PS)
`endif

/* File: rtl/frb_pkg.sv */
`include "frb_defines.svh"
package frb_pkg;
  typedef enum logic [1:0] {
    FRB_M_ARRAY  = 2'h0,
    FRB_M_IDENT  = 2'h1,
    FRB_M_QUERY  = 2'h2,
    FRB_M_STATUS = 2'h3
  } frb_mode_t;
  typedef enum logic [1:0] {
    FRB_BL_4    = 2'h0,
    FRB_BL_8    = 2'h1,
    FRB_BL_16   = 2'h2,
    FRB_BL_CONT = 2'h3
  } frb_blen_t;
  typedef struct packed {
    logic      sync;
    frb_blen_t blen;
    logic      clk_fall;
    logic      wait_hi;
  } frb_cfg_t;
  typedef struct packed {
    logic [`FRB_PART_MAX_W-1:0] part;
    frb_mode_t                  mode;
  } frb_cmd_t;
  typedef struct packed {
    frb_mode_t                  space;
    logic [`FRB_ADDR_MAX_W-1:0] addr;
  } frb_fetch_t;
endpackage : frb_pkg

/* File: rtl/frb_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module frb_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         clr,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("fifo depth must be a power of two");
    end
  endgenerate
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_r;
  logic [AW:0]  rd_r;
  wire          push = in_valid & in_ready;
  wire          pop  = out_valid & out_ready;
  assign in_ready  = (wr_r[AW] == rd_r[AW]) || (wr_r[AW-1:0] != rd_r[AW-1:0]);
  assign out_valid = (wr_r != rd_r);
  assign out_data  = mem[rd_r[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) mem[wr_r[AW-1:0]] <= in_data;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_r <= '0;
      rd_r <= '0;
    end else if (clr) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop) rd_r <= rd_r + 1'b1;
    end
  end
endmodule : frb_fifo
`default_nettype wire

/* File: rtl/frb_part_modes.sv */
`timescale 1ns/1ps
`default_nettype none
module frb_part_modes
  import frb_pkg::*;
#(
  parameter int NPART = 16
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       cmd_valid,
  input  wire frb_cmd_t   cmd,
  output frb_mode_t       modes [NPART]
);
  generate
    if (NPART < 1 || NPART > (1 << `FRB_PART_MAX_W)) begin : g_bad
      $error("partition count out of range");
    end
    for (genvar p = 0; p < NPART; p++) begin : g_part
      wire hit = cmd_valid && (cmd.part == `FRB_PART_MAX_W'(p));
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) modes[p] <= FRB_M_ARRAY;
        else if (hit) modes[p] <= cmd.mode;
      end
    end
  endgenerate
endmodule : frb_part_modes
`default_nettype wire

/* File: rtl/frb_read_if.sv */
`timescale 1ns/1ps
`default_nettype none
module frb_read_if
  import frb_pkg::*;
#(
  parameter int AW = 22
) (
  input  wire logic                  CLOCK,
  input  wire logic                  ARST_N,
  input  wire logic                  BURST_CLK,
  input  wire logic                  CE_N,
  input  wire logic                  OE_N,
  input  wire logic                  WE_N,
  input  wire logic                  ADDRESS_VALID_N,
  input  wire logic [AW-1:0]         A,
  output logic [`FRB_WORD_W-1:0]     DQ_O,
  output logic                       DQ_OE,
  output logic                       WAIT_O,
  output logic                       WAIT_OE,
  input  wire logic                  MODE_CMD_VALID,
  input  wire frb_cmd_t              MODE_CMD,
  input  wire logic                  CFG_LOAD,
  input  wire frb_cfg_t              CFG,
  output logic                       FETCH_VALID,
  output frb_fetch_t                 FETCH,
  input  wire logic                  FETCH_RSP_VALID,
  input  wire logic [`FRB_WORD_W-1:0] FETCH_RSP_DATA
);
  localparam int PW    = AW - `FRB_PART_OFF_W;
  localparam int NPART = 1 << PW;
  generate
    if (AW <= `FRB_PART_OFF_W || AW > `FRB_ADDR_MAX_W || PW > `FRB_PART_MAX_W) begin : g_bad
      $error("address width cannot be served");
    end
  endgenerate

  // pin synchronisers
  logic [`FRB_PIN_W-1:0] pin_s1_r;
  logic [`FRB_PIN_W-1:0] pin_s2_r;
  logic [`FRB_PIN_W-1:0] pin_prev_r;
  logic [AW-1:0]         a_s1_r;
  logic [AW-1:0]         a_s2_r;
  wire  [`FRB_PIN_W-1:0] pin_raw = {BURST_CLK, CE_N, OE_N, WE_N, ADDRESS_VALID_N};

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_s1_r   <= 5'h1E;
      pin_s2_r   <= 5'h1E;
      pin_prev_r <= 5'h1E;
      a_s1_r     <= '0;
      a_s2_r     <= '0;
    end else begin
      pin_s1_r   <= pin_raw;
      pin_s2_r   <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
      a_s1_r     <= A;
      a_s2_r     <= a_s1_r;
    end
  end

  // decoded pin levels and edges
  wire ce        = !pin_s2_r[`FRB_PIN_CE];
  wire oe        = !pin_s2_r[`FRB_PIN_OE];
  wire we        = !pin_s2_r[`FRB_PIN_WE];
  wire adv       = !pin_s2_r[`FRB_PIN_ADV];
  wire adv_prev  = !pin_prev_r[`FRB_PIN_ADV];
  wire bclk      = pin_s2_r[`FRB_PIN_CLK];
  wire bclk_prev = pin_prev_r[`FRB_PIN_CLK];
  wire adv_rise  = adv_prev & !adv;
  wire adv_fall  = !adv_prev & adv;

  // read configuration
  frb_cfg_t cfg_r;
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) cfg_r <= '{sync: 1'b0, blen: FRB_BL_4, clk_fall: 1'b0, wait_hi: 1'b1};
    else if (CFG_LOAD) cfg_r <= CFG;
  end

  wire clk_edge = cfg_r.clk_fall ? (bclk_prev & !bclk) : (!bclk_prev & bclk);
  wire active   = ce & !we;

  // partition modes
  frb_mode_t modes [NPART];
  frb_part_modes #(
    .NPART (NPART)
  ) u_modes (
    .clk       (CLOCK),
    .arst_n    (ARST_N),
    .cmd_valid (MODE_CMD_VALID),
    .cmd       (MODE_CMD),
    .modes     (modes)
  );

  // address latch
  logic [AW-1:0] lat_addr_r;
  logic [AW-1:0] cur_addr_r;
  logic          cur_vld_r;
  logic          captured_r;
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) lat_addr_r <= '0;
    else if (adv) lat_addr_r <= a_s2_r;
  end

  wire [AW-1:0] eff_addr = adv ? a_s2_r : lat_addr_r;
  wire async_start = active & !cfg_r.sync & (!cur_vld_r || eff_addr != cur_addr_r);
  wire sync_start  = active & cfg_r.sync & !captured_r & (adv_rise | (clk_edge & adv));
  wire start       = async_start | sync_start;
  wire [PW-1:0] start_part = eff_addr[AW-1:`FRB_PART_OFF_W];
  frb_mode_t start_mode;
  assign start_mode = modes[start_part];

  // current access
  frb_mode_t     space_r;
  logic          burst_r;
  logic          cont_r;
  logic [4:0]    left_r;
  logic [AW-1:0] idx_r;
  logic [AW-1:0] mask_r;
  logic          pend_r;
  logic          drop_r;

  wire flush = start | !ce;
  wire [4:0] blen_words = (cfg_r.blen == FRB_BL_4) ? 5'h04 :
                          (cfg_r.blen == FRB_BL_8) ? 5'h08 : 5'h10;
  wire [AW-1:0] blen_mask = (cfg_r.blen == FRB_BL_4) ? AW'(4'h3) :
                            (cfg_r.blen == FRB_BL_8) ? AW'(4'h7) :
                            (cfg_r.blen == FRB_BL_16) ? AW'(4'hF) : '0;
  wire start_array = (start_mode == FRB_M_ARRAY);
  wire start_burst = sync_start & start_array;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cur_addr_r <= '0;
      cur_vld_r  <= 1'b0;
      captured_r <= 1'b0;
      space_r    <= FRB_M_ARRAY;
      burst_r    <= 1'b0;
      cont_r     <= 1'b0;
    end else if (!ce) begin
      cur_vld_r  <= 1'b0;
      captured_r <= 1'b0;
      burst_r    <= 1'b0;
      cont_r     <= 1'b0;
    end else if (start) begin
      cur_addr_r <= eff_addr;
      cur_vld_r  <= 1'b1;
      captured_r <= sync_start;
      space_r    <= start_mode;
      burst_r    <= start_burst;
      cont_r     <= start_burst && cfg_r.blen == FRB_BL_CONT;
    end else if (adv_fall) begin
      captured_r <= 1'b0;
    end
  end

  // fetch engine
  wire fifo_in_ready;
  wire can_issue = ce & cur_vld_r & !start & !pend_r & fifo_in_ready & (cont_r | left_r != 5'h00);
  wire [AW-1:0] seq_addr = (cur_addr_r & ~mask_r) | ((cur_addr_r + idx_r) & mask_r);
  wire [AW-1:0] lin_addr = cur_addr_r + idx_r;
  wire [AW-1:0] nxt_fetch_addr = cont_r ? lin_addr : seq_addr;
  wire rsp_take = FETCH_RSP_VALID & pend_r;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      left_r <= 5'h00;
      idx_r  <= '0;
      mask_r <= '0;
    end else if (start) begin
      left_r <= start_burst ? blen_words : 5'h01;
      idx_r  <= '0;
      mask_r <= blen_mask;
    end else if (!ce) begin
      left_r <= 5'h00;
    end else if (can_issue) begin
      left_r <= cont_r ? left_r : left_r - 5'h01;
      idx_r  <= idx_r + 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pend_r <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      if (can_issue) pend_r <= 1'b1;
      else if (rsp_take) pend_r <= 1'b0;
      if (flush && pend_r && !rsp_take) drop_r <= 1'b1;
      else if (rsp_take) drop_r <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      FETCH_VALID <= 1'b0;
      FETCH       <= '0;
    end else begin
      FETCH_VALID <= can_issue;
      if (can_issue) begin
        FETCH.space <= space_r;
        FETCH.addr  <= `FRB_ADDR_MAX_W'(nxt_fetch_addr);
      end
    end
  end

  // data buffer between fetch and pins
  wire                    fifo_out_valid;
  wire [`FRB_WORD_W-1:0]  fifo_out_data;
  wire                    burst_pop = burst_r & captured_r & clk_edge & !adv;
  wire                    single_pop = !burst_r & cur_vld_r;
  wire                    pop = fifo_out_valid & (burst_pop | single_pop);
  logic                   data_ok_r;

  frb_fifo #(
    .W     (`FRB_WORD_W),
    .DEPTH (`FRB_FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLOCK),
    .arst_n    (ARST_N),
    .clr       (flush),
    .in_valid  (rsp_take & !drop_r & !flush),
    .in_ready  (fifo_in_ready),
    .in_data   (FETCH_RSP_DATA),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  logic [`FRB_WORD_W-1:0] dq_r;
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      dq_r      <= '0;
      data_ok_r <= 1'b0;
    end else if (flush) begin
      data_ok_r <= 1'b0;
    end else if (pop) begin
      dq_r      <= fifo_out_data;
      data_ok_r <= 1'b1;
    end else if (burst_pop) begin
      data_ok_r <= 1'b0;
    end
  end

  // pin drivers
  wire wait_busy = !(burst_r & cur_vld_r) | !data_ok_r;
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      DQ_O    <= '0;
      DQ_OE   <= 1'b0;
      WAIT_O  <= 1'b0;
      WAIT_OE <= 1'b0;
    end else begin
      DQ_O    <= dq_r;
      DQ_OE   <= active & oe;
      WAIT_O  <= cfg_r.wait_hi ? wait_busy : !wait_busy;
      WAIT_OE <= ce;
    end
  end
endmodule : frb_read_if
`default_nettype wire

/* File: dv/frb_read_if_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module frb_read_if_sva
  import frb_pkg::*;
(
  input wire logic       CLOCK,
  input wire logic       ARST_N,
  input wire logic       CE_N,
  input wire logic       OE_N,
  input wire logic       WE_N,
  input wire logic       DQ_OE,
  input wire logic       WAIT_OE,
  input wire logic       FETCH_VALID,
  input wire frb_fetch_t FETCH
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  a_standby_float: assert property (
    CE_N [*4] |-> !DQ_OE && !WAIT_OE) else $error("outputs driven while deselected");
  a_read_drives: assert property (
    (!CE_N && !OE_N && WE_N) [*4] |-> DQ_OE) else $error("data not driven in read");
  a_write_blocks: assert property (
    !WE_N [*4] |-> !DQ_OE) else $error("data driven while write enable low");
  a_wait_selected: assert property (
    !CE_N [*4] |-> WAIT_OE) else $error("wait not driven while selected");
  a_fetch_single: assert property (
    FETCH_VALID |=> !FETCH_VALID) else $error("fetch pulse longer than one cycle");
  a_fetch_hold: assert property (
    !FETCH_VALID |-> $stable(FETCH)) else $error("fetch request changed without pulse");
  a_deselect_nofetch: assert property (
    CE_N [*4] |-> !FETCH_VALID) else $error("fetch while deselected");
  a_reset_quiet: assert property (
    $rose(ARST_N) |-> !DQ_OE && !WAIT_OE && !FETCH_VALID) else $error("outputs on at reset");
endmodule : frb_read_if_sva
bind frb_read_if frb_read_if_sva i_frb_read_if_sva (.CLOCK(CLOCK), .ARST_N(ARST_N),
  .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N), .DQ_OE(DQ_OE), .WAIT_OE(WAIT_OE),
  .FETCH_VALID(FETCH_VALID), .FETCH(FETCH));
`default_nettype wire

/* File: dv/frb_store_model.sv */
`timescale 1ns/1ps
`default_nettype none
module frb_store_model
  import frb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       fetch_valid,
  input  wire frb_fetch_t fetch,
  input  wire logic [3:0] lat,
  output logic            rsp_valid,
  output logic [15:0]     rsp_data
);
  logic [3:0] cnt_r;
  logic       busy_r;
  frb_fetch_t req_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r     <= 4'h0;
      busy_r    <= 1'b0;
      req_r     <= '0;
      rsp_valid <= 1'b0;
      rsp_data  <= 16'h0;
    end else begin
      rsp_valid <= 1'b0;
      rsp_data  <= ~rsp_data;
      if (fetch_valid) begin
        busy_r <= 1'b1;
        cnt_r  <= lat;
        req_r  <= fetch;
      end else if (busy_r && cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (busy_r) begin
        busy_r    <= 1'b0;
        rsp_valid <= 1'b1;
        rsp_data  <= {req_r.space, req_r.addr[13:0]};
      end
    end
  end
endmodule : frb_store_model
`default_nettype wire

/* File: dv/tb_frb_read_if.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_frb_read_if;
  import frb_pkg::*;
  logic        clk = 0, arst_n = 0, bclk = 0, ce_n = 1, oe_n = 1, we_n = 1, adv_n = 1;
  logic        mcv = 0, cfgl = 0, fv, rv, dq_oe, wt, wt_oe;
  logic [3:0]  lat = 4'h1;
  logic [21:0] a = 22'h0;
  logic [15:0] dq, rd;
  frb_cmd_t    mcmd = '0;
  frb_cfg_t    cfg = '0;
  frb_fetch_t  fetch;
  int          fail_count = 0, n_checks = 0;
  always #2 clk = ~clk;
  frb_read_if i_frb_read_if (.CLOCK(clk), .ARST_N(arst_n), .BURST_CLK(bclk), .CE_N(ce_n),
    .OE_N(oe_n), .WE_N(we_n), .ADDRESS_VALID_N(adv_n), .A(a), .DQ_O(dq), .DQ_OE(dq_oe),
    .WAIT_O(wt), .WAIT_OE(wt_oe), .MODE_CMD_VALID(mcv), .MODE_CMD(mcmd), .CFG_LOAD(cfgl),
    .CFG(cfg), .FETCH_VALID(fv), .FETCH(fetch), .FETCH_RSP_VALID(rv), .FETCH_RSP_DATA(rd));
  frb_store_model i_frb_store_model (.clk(clk), .arst_n(arst_n), .fetch_valid(fv),
    .fetch(fetch), .lat(lat), .rsp_valid(rv), .rsp_data(rd));
  function automatic logic [15:0] ex(frb_mode_t m, logic [21:0] ad);
    return {m, ad[13:0]};
  endfunction : ex
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wait_dq(logic [15:0] e);
    int i;
    for (i = 0; i < 80 && !(dq === e && dq_oe === 1'b1); i++) @(posedge clk);
    chk(dq, e);
    if (i == 80) begin
      fail_count++;
      give_verdict();
    end
  endtask : wait_dq
  task automatic set_mode(logic [7:0] p, frb_mode_t m);
    @(posedge clk);
    mcv  <= 1'b1;
    mcmd <= '{part: p, mode: m};
    @(posedge clk);
    mcv <= 1'b0;
  endtask : set_mode
  task automatic aread(logic [21:0] ad, frb_mode_t m);
    @(posedge clk);
    ce_n  <= 1'b0;
    oe_n  <= 1'b0;
    we_n  <= 1'b1;
    adv_n <= 1'b0;
    a     <= ad;
    wait_dq(ex(m, ad));
  endtask : aread
  task automatic bedge();
    @(posedge clk);
    bclk <= 1'b0;
    cyc(8);
    bclk <= 1'b1;
    cyc(8);
  endtask : bedge
  task automatic t_async();
    aread(22'h000123, FRB_M_ARRAY);
    chk(fetch.addr, 32'h123);
    aread(22'h000200, FRB_M_ARRAY);
    adv_n <= 1'b1;
    cyc(1);
    a <= 22'h000321;
    cyc(30);
    chk(dq, ex(FRB_M_ARRAY, 22'h000200));
    adv_n <= 1'b0;
    wait_dq(ex(FRB_M_ARRAY, 22'h000321));
  endtask : t_async
  task automatic t_modes();
    for (int m = 1; m < 4; m++) begin
      set_mode(8'h2, frb_mode_t'(m));
      aread(22'h080010 + 22'(m), frb_mode_t'(m));
      chk(wt, 1);
      aread(22'h000050 + 22'(m), FRB_M_ARRAY);
    end
    set_mode(8'h2, FRB_M_ARRAY);
    aread(22'h080020, FRB_M_ARRAY);
  endtask : t_modes
  task automatic t_block();
    ce_n <= 1'b1;
    cyc(6);
    chk({dq_oe, wt_oe}, 0);
    ce_n <= 1'b0;
    we_n <= 1'b0;
    cyc(6);
    chk(dq_oe, 0);
    we_n <= 1'b1;
    oe_n <= 1'b1;
    cyc(6);
    chk(dq_oe, 0);
    oe_n <= 1'b0;
    cyc(6);
    chk(dq_oe, 1);
  endtask : t_block
  task automatic t_burst();
    int win, st, k;
    for (int b = 0; b < 4; b++) begin
      win = 4 << b;
      st = win - 2;
      lat <= (b > 1) ? 4'h9 : 4'h1;
      ce_n <= 1'b1;
      cfgl <= 1'b1;
      cfg <= '{sync: 1'b1, blen: frb_blen_t'(b), clk_fall: 1'b0, wait_hi: 1'b1};
      cyc(1);
      cfgl <= 1'b0;
      cyc(6);
      ce_n <= 1'b0;
      oe_n <= 1'b0;
      adv_n <= 1'b0;
      a <= 22'h0C0000 + 22'(st);
      bedge();
      adv_n <= 1'b1;
      for (int i = 0; i < ((b == 0) ? 4 : 5); i++) begin
        if (b == 0 && i == 2) begin
          oe_n <= 1'b1;
          cyc(250);
          chk(wt_oe, 1);
          oe_n <= 1'b0;
        end
        for (k = 0; k < 20; k++) begin
          bedge();
          if (wt === 1'b0) break;
        end
        chk(dq, ex(FRB_M_ARRAY, 22'h0C0000 + 22'((b == 3) ? st + i : (st + i) % win)));
        if (k == 20) begin
          fail_count++;
          give_verdict();
        end
      end
    end
  endtask : t_burst
  task automatic t_sync_status();
    set_mode(8'h3, FRB_M_STATUS);
    ce_n <= 1'b1;
    cyc(6);
    ce_n <= 1'b0;
    adv_n <= 1'b0;
    a <= 22'h0C0040;
    bedge();
    adv_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      bedge();
      chk(wt, 1);
    end
    chk(fetch.addr, 32'h0C0040);
  endtask : t_sync_status
  task automatic t_reset();
    bclk <= 1'b1;
    arst_n <= 1'b0;
    cyc(25);
    chk({dq_oe, wt_oe, fv}, 0);
    arst_n <= 1'b1;
    aread(22'h0C0077, FRB_M_ARRAY);
  endtask : t_reset
  initial begin
    bclk <= 1'b1;
    cyc(3);
    chk({dq_oe, wt_oe}, 0);
    arst_n <= 1'b1;
    t_async();
    t_modes();
    t_block();
    t_burst();
    t_sync_status();
    t_reset();
    give_verdict();
  end
endmodule : tb_frb_read_if
`default_nettype wire
